// ===== include/xfer_regs_map.vh
/*
 * register map, field positions, reset values and constants of the
 * transfer control/status register block.
 * assumes inclusion by bare name from a design file.
 */
`ifndef XFER_REGS_MAP_VH
`define XFER_REGS_MAP_VH

`define ADDR_CTRL_STATUS   5'h00
`define ADDR_INFO_BASE     5'h04
`define ADDR_IRQ_STATUS    5'h08
`define ADDR_IRQ_ENABLE    5'h0c
`define ADDR_IRQ_CLEAR     5'h10

`define BIT_NMI_FLAG       10
`define BIT_ADDR_ERR       9
`define BIT_SOFT_EN        8
`define VEC_MSB            7
`define VEC_LSB            0

`define SOFT_VEC_BASE      16'h0400
`define CTRL_RESET         16'h0000
`define INFO_BASE_RESET    16'h0000

`define IRQ_NMI            0
`define IRQ_AERR           1
`define IRQ_SOFT           2
`define IRQ_BITS           3

`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`define SIZE_BYTE          2'b00
`define SIZE_WORD          2'b01
`define SIZE_LONG          2'b10

`endif

// ===== hw/xfer_ctrl_status_regs.v
/*
 * control/status and information-base registers of a data transfer
 * controller, reached over an axi4-lite slave, with an interrupt block.
 * assumes the transfer engine sits outside: it reports nmi, its access
 * addresses and sizes, and asks whether it may start a transfer.
 */
// How it works
// - bits 15..11 read zero, writes ignored
// - nmi event sets flag at bit 10
// - nmi flag blocks new starts, continue mode finishes
// - controller address error sets bit 9 flag
// - address error flag blocks all transfers
// - flags clear by zero-write after one-read
// - bit 8 one activates software transfer
// - enable clears only after read as one
// - software vector address is 0x0400 plus field
// - vector writable only while enable is zero
// - base register gives upper 16 address bits
// - info start address is base plus table entry
// - start only on software request; source_request unused
`include "xfer_regs_map.vh"

module xfer_ctrl_status_regs (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        nmi_event,
    input  wire        source_request,
    input  wire        xfer_busy,
    input  wire        nmi_continue_mode,
    input  wire        access_valid,
    input  wire [31:0] access_addr,
    input  wire [1:0]  access_size,
    input  wire [15:0] vector_entry,
    output wire        start_allowed,
    output wire        xfer_abort,
    output reg         soft_start,
    output reg  [15:0] soft_vector_addr,
    output reg  [31:0] info_start_addr,
    output reg  [15:0] info_base,
    output wire        irq
);

    reg        nmi_flag_q;
    reg        addr_error_flag_q;
    reg        soft_activation_enable_q;
    reg  [7:0] soft_vector_field_q;
    reg  [15:0] transfer_info_base_q;
    reg        nmi_seen_q;
    reg        aerr_seen_q;
    reg        en_seen_q;
    reg  [`IRQ_BITS-1:0] irq_status_q;
    reg  [`IRQ_BITS-1:0] irq_enable_q;
    reg        aw_held_q;
    reg        w_held_q;
    reg  [4:0] aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0] w_strb_q;

    wire        do_write;
    wire        do_read;
    wire [15:0] ctrl_read;
    wire        misaligned;
    wire        wr_ctrl;
    wire        wr_base;
    wire        wr_irq_en;
    wire        wr_irq_clr;
    wire        ctrl_lo_lane;
    wire        ctrl_hi_lane;
    wire        soft_en_rise;

    function [15:0] ctrl_word;
        input       nmi_f;
        input       aerr_f;
        input       en_f;
        input [7:0] vec;
        begin
            ctrl_word = {5'h00, nmi_f, aerr_f, en_f, vec};
        end
    endfunction

    function addr_known;
        input [4:0] a;
        begin
            addr_known = (a == `ADDR_CTRL_STATUS) || (a == `ADDR_INFO_BASE) ||
                         (a == `ADDR_IRQ_STATUS) || (a == `ADDR_IRQ_ENABLE) ||
                         (a == `ADDR_IRQ_CLEAR);
        end
    endfunction

    // write address and data are latched independently, in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read       = s_axi_arvalid && s_axi_arready;

    assign ctrl_read    = ctrl_word(nmi_flag_q, addr_error_flag_q,
                                    soft_activation_enable_q, soft_vector_field_q);
    assign wr_ctrl      = do_write && (aw_addr_q == `ADDR_CTRL_STATUS);
    assign wr_base      = do_write && (aw_addr_q == `ADDR_INFO_BASE);
    assign wr_irq_en    = do_write && (aw_addr_q == `ADDR_IRQ_ENABLE);
    assign wr_irq_clr   = do_write && (aw_addr_q == `ADDR_IRQ_CLEAR);
    assign ctrl_lo_lane = w_strb_q[0];
    assign ctrl_hi_lane = w_strb_q[1];

    // a byte write would corrupt the base, so it is refused outright
    wire base_full = (w_strb_q[1:0] == 2'b11);

    assign misaligned = access_valid &&
        (((access_size == `SIZE_WORD) && access_addr[0]) ||
         ((access_size == `SIZE_LONG) && (access_addr[1:0] != 2'b00)));

    assign start_allowed = !nmi_flag_q && !addr_error_flag_q;
    // an nmi stops a running transfer unless continue mode was chosen
    assign xfer_abort = xfer_busy && ((nmi_flag_q && !nmi_continue_mode) ||
                                      addr_error_flag_q);
    assign soft_en_rise = wr_ctrl && ctrl_hi_lane && w_data_q[`BIT_SOFT_EN] &&
                          !soft_activation_enable_q;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[4:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (!addr_known(aw_addr_q) ||
                                 (wr_base && !base_full)) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_known({s_axi_araddr[4:2], 2'b00}) ? `RESP_OKAY
                                                                 : `RESP_SLVERR;
            case ({s_axi_araddr[4:2], 2'b00})
                `ADDR_CTRL_STATUS: s_axi_rdata <= {16'h0000, ctrl_read};
                `ADDR_INFO_BASE:   s_axi_rdata <= {16'h0000, transfer_info_base_q};
                `ADDR_IRQ_STATUS:  s_axi_rdata <= {29'h00000000, irq_status_q};
                `ADDR_IRQ_ENABLE:  s_axi_rdata <= {29'h00000000, irq_enable_q};
                default:           s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    wire rd_ctrl = do_read && ({s_axi_araddr[4:2], 2'b00} == `ADDR_CTRL_STATUS);

    // flags: hardware set wins over a software clear in the same cycle
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            nmi_flag_q        <= 1'b0;
            addr_error_flag_q <= 1'b0;
            nmi_seen_q        <= 1'b0;
            aerr_seen_q       <= 1'b0;
            en_seen_q         <= 1'b0;
        end else begin
            if (rd_ctrl) begin
                nmi_seen_q  <= nmi_flag_q;
                aerr_seen_q <= addr_error_flag_q;
                en_seen_q   <= soft_activation_enable_q;
            end
            if (nmi_event) begin
                nmi_flag_q <= 1'b1;
            end else if (wr_ctrl && ctrl_hi_lane && !w_data_q[`BIT_NMI_FLAG] &&
                         nmi_seen_q) begin
                nmi_flag_q <= 1'b0;
                nmi_seen_q <= 1'b0;
            end
            if (misaligned) begin
                addr_error_flag_q <= 1'b1;
            end else if (wr_ctrl && ctrl_hi_lane && !w_data_q[`BIT_ADDR_ERR] &&
                         aerr_seen_q) begin
                addr_error_flag_q <= 1'b0;
                aerr_seen_q       <= 1'b0;
            end
            if (wr_ctrl && ctrl_hi_lane && !w_data_q[`BIT_SOFT_EN] && en_seen_q) begin
                en_seen_q <= 1'b0;
            end
        end
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            soft_activation_enable_q <= 1'b0;
            soft_vector_field_q      <= 8'h00;
            transfer_info_base_q     <= `INFO_BASE_RESET;
            soft_start               <= 1'b0;
        end else begin
            soft_start <= soft_en_rise && start_allowed;
            if (wr_ctrl && ctrl_hi_lane) begin
                if (w_data_q[`BIT_SOFT_EN]) begin
                    soft_activation_enable_q <= 1'b1;
                end else if (en_seen_q) begin
                    soft_activation_enable_q <= 1'b0;
                end
            end
            if (wr_ctrl && ctrl_lo_lane && !soft_activation_enable_q) begin
                soft_vector_field_q <= w_data_q[`VEC_MSB:`VEC_LSB];
            end
            if (wr_base && base_full) begin
                transfer_info_base_q <= w_data_q[15:0];
            end
        end
    end

    // addresses handed to the engine; registered for clean data outputs
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            soft_vector_addr <= `SOFT_VEC_BASE;
            info_start_addr  <= 32'h00000000;
            info_base        <= `INFO_BASE_RESET;
        end else begin
            soft_vector_addr <= `SOFT_VEC_BASE + {8'h00, soft_vector_field_q};
            info_start_addr  <= {transfer_info_base_q, vector_entry};
            info_base        <= transfer_info_base_q;
        end
    end

    // sticky interrupt status; set wins over clear
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_status_q <= 3'h0;
            irq_enable_q <= 3'h0;
        end else begin
            if (wr_irq_en) begin
                irq_enable_q <= w_data_q[`IRQ_BITS-1:0];
            end
            irq_status_q <= (irq_status_q &
                             ~(wr_irq_clr ? w_data_q[`IRQ_BITS-1:0] : 3'h0)) |
                            {soft_start, misaligned, nmi_event};
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);

    // source_request is unused: it never starts a transfer, blocked or not
    wire unused_src = source_request;

endmodule

// ===== tb/xfer_regs_props.sv
/* port assertions of the transfer control/status register block.
   assumes the bind below, one clock and the active-low reset. */
module xfer_regs_props (
    input logic        sys_clk,
    input logic        rstn,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        nmi_event,
    input logic        xfer_busy,
    input logic        nmi_continue_mode,
    input logic        access_valid,
    input logic [31:0] access_addr,
    input logic [1:0]  access_size,
    input logic [15:0] vector_entry,
    input logic        start_allowed,
    input logic        xfer_abort,
    input logic        soft_start,
    input logic [15:0] soft_vector_addr,
    input logic [31:0] info_start_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // word wants an even address, longword a multiple of four
    sequence s_misaligned;
        access_valid && ((access_size == 2'b01 && access_addr[0])
            || (access_size == 2'b10 && access_addr[1:0] != 2'b00));
    endsequence
    sequence s_read_stall;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_nmi_blocks: assert property (nmi_event |=> !start_allowed)
        else $error("start allowed after nmi");
    a_misalign_err: assert property (s_misaligned |=> !start_allowed)
        else $error("misaligned access left start allowed");
    a_abort_stop: assert property (xfer_busy && !start_allowed && !nmi_continue_mode
        |-> xfer_abort) else $error("blocked transfer not aborted");
    // an odd vector here means software broke the even-vector convention
    a_vec_base: assert property (soft_vector_addr[15:8] == 8'h04 && !soft_vector_addr[0])
        else $error("soft vector outside base page or odd");
    a_info_low: assert property (##1 info_start_addr[15:0] == $past(vector_entry))
        else $error("info address low half wrong");
    a_soft_pulse: assert property (soft_start |=> !soft_start)
        else $error("soft start longer than one cycle");
    a_read_stands: assert property (s_read_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
endmodule

bind xfer_ctrl_status_regs xfer_regs_props props (.*);

// ===== tb/transfer_ctrl_status_regs_tb_top.sv
/* self-checking bench for the transfer control/status register block.
   assumes the register map header and the axi4-lite slave of the block. */
`include "xfer_regs_map.vh"
module transfer_ctrl_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, nmi_event, source_request, xfer_busy, nmi_continue_mode;
    logic        access_valid, start_allowed, xfer_abort, soft_start, irq;
    logic [4:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, access_addr, info_start_addr;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, access_size;
    logic [15:0] vector_entry, soft_vector_addr, info_base;
    int          miscompares, compares, soft_n, k;
    logic [1:0]  sz [4] = '{2'b00, 2'b01, 2'b10, 2'b10};
    logic [1:0]  lo [4] = '{2'b01, 2'b10, 2'b00, 2'b10};
    logic        ok [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    xfer_ctrl_status_regs dut (.*);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (soft_start === 1'b1) soft_n <= soft_n + 1;
    task automatic final_report;
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] er);
        logic        ta, tw, td;
        logic [31:0] dt;
        logic [1:0]  rp;
        int          i;
        @(posedge sys_clk);
        if (wr) begin
            {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
        end
        for (i = 0; i < 50; i++) begin
            @(negedge sys_clk);
            ta = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
            tw = s_axi_wvalid && s_axi_wready;
            td = wr ? s_axi_bvalid : s_axi_rvalid && s_axi_rready;
            dt = wr ? d : s_axi_rdata;
            rp = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge sys_clk);
            if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (tw) s_axi_wvalid <= 1'b0;
            if (td) break;
            // rready waits for rvalid so that a stalled answer is seen too
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (i == 50) begin
            miscompares++;
            final_report();
        end else begin
            chk("resp", er, rp);
            chk("data", d, dt);
        end
    endtask
    initial begin
        rstn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, nmi_event} = '0;
        {source_request, xfer_busy, nmi_continue_mode, access_valid} = '0;
        {access_addr, access_size, vector_entry} = '0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        bus(0, `ADDR_CTRL_STATUS, 32'h0, 4'h3, `RESP_OKAY);
        bus(0, `ADDR_IRQ_STATUS, 32'h0, 4'hf, `RESP_OKAY);
        bus(0, 5'h14, 32'h0, 4'hf, `RESP_SLVERR);
        chk("svec", 32'h400, soft_vector_addr);
        bus(1, `ADDR_CTRL_STATUS, 32'hfe10, 4'h3, `RESP_OKAY);
        bus(0, `ADDR_CTRL_STATUS, 32'h10, 4'h3, `RESP_OKAY);
        chk("svec", 32'h410, soft_vector_addr);
        bus(1, `ADDR_CTRL_STATUS, 32'h110, 4'h3, `RESP_OKAY);
        bus(1, `ADDR_CTRL_STATUS, 32'h120, 4'h3, `RESP_OKAY);
        bus(1, `ADDR_CTRL_STATUS, 32'h0, 4'h3, `RESP_OKAY);
        bus(0, `ADDR_CTRL_STATUS, 32'h110, 4'h3, `RESP_OKAY);
        bus(1, `ADDR_CTRL_STATUS, 32'h0, 4'h3, `RESP_OKAY);
        bus(0, `ADDR_CTRL_STATUS, 32'h10, 4'h3, `RESP_OKAY);
        chk("starts", 32'h1, soft_n);
        nmi_event <= 1'b1;
        @(posedge sys_clk);
        {nmi_event, xfer_busy} <= 2'b01;
        @(negedge sys_clk);
        chk("allowed", 32'h0, start_allowed);
        chk("abort", 32'h1, xfer_abort);
        @(posedge sys_clk);
        nmi_continue_mode <= 1'b1;
        @(negedge sys_clk);
        chk("abort", 32'h0, xfer_abort);
        bus(1, `ADDR_CTRL_STATUS, 32'h10, 4'h3, `RESP_OKAY);
        bus(0, `ADDR_CTRL_STATUS, 32'h410, 4'h3, `RESP_OKAY);
        bus(1, `ADDR_CTRL_STATUS, 32'h10, 4'h3, `RESP_OKAY);
        for (k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            {access_valid, access_size, access_addr} <= {1'b1, sz[k], 30'h1, lo[k]};
            @(posedge sys_clk);
            access_valid <= 1'b0;
            @(negedge sys_clk);
            chk("allowed", ok[k], start_allowed);
        end
        chk("abort", 32'h1, xfer_abort);
        bus(0, `ADDR_CTRL_STATUS, 32'h210, 4'h3, `RESP_OKAY);
        bus(1, `ADDR_CTRL_STATUS, 32'h10, 4'h3, `RESP_OKAY);
        chk("allowed", 32'h1, start_allowed);
        bus(0, `ADDR_IRQ_STATUS, 32'h7, 4'hf, `RESP_OKAY);
        chk("irq", 32'h0, irq);
        bus(1, `ADDR_IRQ_ENABLE, 32'h1, 4'hf, `RESP_OKAY);
        chk("irq", 32'h1, irq);
        bus(1, 5'h10, 32'h1, 4'hf, `RESP_OKAY);
        chk("irq", 32'h0, irq);
        bus(1, `ADDR_IRQ_ENABLE, 32'h7, 4'hf, `RESP_OKAY);
        chk("irq", 32'h1, irq);
        bus(1, 5'h10, 32'h6, 4'hf, `RESP_OKAY);
        bus(0, `ADDR_IRQ_STATUS, 32'h0, 4'hf, `RESP_OKAY);
        chk("irq", 32'h0, irq);
        bus(1, `ADDR_INFO_BASE, 32'h1234, 4'h3, `RESP_OKAY);
        bus(1, `ADDR_INFO_BASE, 32'h55, 4'h1, `RESP_SLVERR);
        bus(0, `ADDR_INFO_BASE, 32'h1234, 4'h3, `RESP_OKAY);
        vector_entry <= 16'h5678;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("info", 32'h12345678, info_start_addr);
        chk("base", 32'h1234, info_base);
        final_report();
    end
endmodule
